// >>> design/sasc_pkg.sv
// Purpose: shared constants and types of the converter sequencer control
// Assumes: 16-bit register bus, 12-bit conversion results
// Notes: word addresses on the register port

package sasc_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int RES_W = 12;

   // Register word addresses
   localparam logic [4:0] OFF_CTRL1 = 5'h00;
   localparam logic [4:0] OFF_CTRL2 = 5'h01;
   localparam logic [4:0] OFF_CTRL3 = 5'h02;
   localparam logic [4:0] OFF_CHSEL = 5'h03;
   localparam logic [4:0] OFF_PCFG = 5'h04;
   localparam logic [4:0] OFF_PORT = 5'h05;
   localparam logic [4:0] OFF_STAT = 5'h06;
   localparam logic [4:0] OFF_BUF = 5'h10;

   // Field positions
   localparam int C1_ON = 15;
   localparam int C1_SIDL = 13;
   localparam int C1_FORM = 8;
   localparam int C1_SSRC = 5;
   localparam int C1_SAMPLE_ENABLE = 1;
   localparam int C1_DONE = 0;
   localparam int C2_SAMPLES_PER_INTERRUPT = 2;
   localparam int C3_AUTO_SAMPLE_TIME = 8;
   localparam int C3_RC = 7;
   localparam int C3_DIV = 0;
   localparam int ST_CONVB = 0;
   localparam int ST_IRQB = 1;
   localparam int ST_PDB = 2;

   // Trigger sources and output formats
   localparam logic [2:0] TRIG_SW = 3'h0;
   localparam logic [2:0] TRIG_EXT = 3'h1;
   localparam logic [2:0] TRIG_TMR = 3'h2;
   localparam logic [2:0] TRIG_AUTO = 3'h7;
   localparam logic [1:0] FMT_INT = 2'h0;
   localparam logic [1:0] FMT_SINT = 2'h1;
   localparam logic [1:0] FMT_FRAC = 2'h2;
   localparam logic [1:0] FMT_SFRAC = 2'h3;

   // Counts and reset values
   localparam logic [4:0] CONVERTING_FLAG_TADS = 5'h0f;
   localparam logic [6:0] HALF_STEP = 7'h02;
   localparam logic [15:0] RST_WORD = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_SAMPLE = 4'h2,
      ST_WAIT = 4'h4,
      ST_CONVERTING_FLAG = 4'h8
   } sasc_state_type;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } sasc_bus_type;

   typedef struct packed {
      logic [3:0] channel;
      logic sample;
      logic convert;
      logic powered;
   } sasc_afe_type;

   typedef struct packed {
      logic on;
      logic sidl;
      logic [1:0] form;
      logic [2:0] ssrc;
      logic sample_enable;
      logic done;
      logic [3:0] samples_per_interrupt;
      logic [4:0] auto_sample_time;
      logic rc;
      logic [5:0] div;
      logic [3:0] chsel;
      logic [15:0] pcfg;
      logic irqf;
      logic pd;
      logic wake;
      sasc_state_type state;
      logic [6:0] acc;
      logic [4:0] cnt;
      logic [3:0] smp_cnt;
      logic [3:0] idx;
      logic [15:0] rdata;
      logic rc_s1;
      logic rc_s2;
      logic rc_s3;
      logic [15:0] pin_s1;
      logic [15:0] pin_s2;
   } sasc_regs_type;
endpackage

// >>> design/sasc_top.sv
// Purpose: sequencer control of a 12-bit successive approximation converter
// Assumes: analog front end outside, result valid when convert ends
// Notes: one clock, clk_i is the instruction cycle

`timescale 1ns/1ps

module sasc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire sasc_pkg::sasc_bus_type bus_i,
   output logic [sasc_pkg::DATA_W-1:0] rdata_o,
   // Analog front end
   input wire logic [sasc_pkg::RES_W-1:0] afe_result_i,
   output sasc_pkg::sasc_afe_type afe_o,
   // Pins and oscillator
   input wire logic rc_osc_i,
   input wire logic [15:0] pin_i,
   // System state and triggers
   input wire logic sleep_i,
   input wire logic idle_i,
   input wire logic irq_enable_i,
   input wire logic timer_trig_i,
   input wire logic ext_trig_i,
   // Status
   output logic converting_o,
   output logic done_o,
   output logic converter_irq_flag_o,
   output logic wake_o
);
   import sasc_pkg::*;

   sasc_regs_type r;
   sasc_regs_type next_r;
   logic [RES_W-1:0] result_mem [16];
   logic mem_wr;
   logic [RES_W-1:0] mem_data;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      return a == off;
   endfunction

   // Zero, sign or left-justified view of a stored result
   function automatic logic [15:0] fmt(input logic [1:0] f,
                                      input logic [RES_W-1:0] d);
      case (f)
         FMT_INT: fmt = {4'h0, d};
         FMT_SINT: fmt = {{4{d[11]}}, d};
         FMT_FRAC: fmt = {d, 4'h0};
         FMT_SFRAC: fmt = {d, 4'h0};
         default: fmt = {4'h0, d};
      endcase
   endfunction

   logic run;
   logic halt;
   logic tick;
   logic start;
   logic [6:0] half;
   logic [6:0] sum;

   always_comb begin
      next_r = r;
      next_r.wake = 1'b0;
      next_r.rdata = RST_WORD;
      mem_wr = 1'b0;
      mem_data = '0;
      start = 1'b0;
      tick = 1'b0;
      // Synchronisers; first stages feed only the second
      next_r.rc_s1 = rc_osc_i;
      next_r.rc_s2 = r.rc_s1;
      next_r.rc_s3 = r.rc_s2;
      next_r.pin_s1 = pin_i;
      next_r.pin_s2 = r.pin_s1;

      // Module clocks stop when off, powered down, halted or in sleep on the instruction clock
      halt = idle_i & r.sidl;
      run = r.on & ~r.pd & ~halt & (~sleep_i | r.rc);
      half = {1'b0, r.div} + 7'h01;
      sum = r.acc + HALF_STEP;
      if (run) begin
         if (r.rc) begin
            tick = r.rc_s2 & ~r.rc_s3;
         end else if (sum >= half) begin
            // Half-cycle steps: period is (div+1)/2 cycles on average
            tick = 1'b1;
            next_r.acc = sum - half;
         end else begin
            next_r.acc = sum;
         end
      end

      // Register writes
      if (bus_i.wr) begin
         if (hit(bus_i.addr, OFF_CTRL1)) begin
            next_r.on = bus_i.wdata[C1_ON];
            next_r.sidl = bus_i.wdata[C1_SIDL];
            next_r.form = bus_i.wdata[C1_FORM +: 2];
            next_r.ssrc = bus_i.wdata[C1_SSRC +: 3];
            next_r.sample_enable = bus_i.wdata[C1_SAMPLE_ENABLE];
            if (!bus_i.wdata[C1_DONE]) begin
               next_r.done = 1'b0;
            end
         end
         if (hit(bus_i.addr, OFF_CTRL2)) begin
            next_r.samples_per_interrupt = bus_i.wdata[C2_SAMPLES_PER_INTERRUPT +: 4];
         end
         if (hit(bus_i.addr, OFF_CTRL3)) begin
            next_r.auto_sample_time = bus_i.wdata[C3_AUTO_SAMPLE_TIME +: 5];
            next_r.rc = bus_i.wdata[C3_RC];
            next_r.div = bus_i.wdata[C3_DIV +: 6];
         end
         if (hit(bus_i.addr, OFF_CHSEL)) begin
            next_r.chsel = bus_i.wdata[3:0];
         end
         if (hit(bus_i.addr, OFF_PCFG)) begin
            next_r.pcfg = bus_i.wdata;
         end
         if (hit(bus_i.addr, OFF_STAT) && !bus_i.wdata[ST_IRQB]) begin
            next_r.irqf = 1'b0;
         end
      end

      // Register reads, answered one cycle later
      if (bus_i.rd) begin
         if (hit(bus_i.addr, OFF_CTRL1)) begin
            next_r.rdata[C1_ON] = r.on;
            next_r.rdata[C1_SIDL] = r.sidl;
            next_r.rdata[C1_FORM +: 2] = r.form;
            next_r.rdata[C1_SSRC +: 3] = r.ssrc;
            next_r.rdata[C1_SAMPLE_ENABLE] = r.sample_enable;
            next_r.rdata[C1_DONE] = r.done;
         end else if (hit(bus_i.addr, OFF_CTRL2)) begin
            next_r.rdata[C2_SAMPLES_PER_INTERRUPT +: 4] = r.samples_per_interrupt;
         end else if (hit(bus_i.addr, OFF_CTRL3)) begin
            next_r.rdata[C3_AUTO_SAMPLE_TIME +: 5] = r.auto_sample_time;
            next_r.rdata[C3_RC] = r.rc;
            next_r.rdata[C3_DIV +: 6] = r.div;
         end else if (hit(bus_i.addr, OFF_CHSEL)) begin
            next_r.rdata[3:0] = r.chsel;
         end else if (hit(bus_i.addr, OFF_PCFG)) begin
            next_r.rdata = r.pcfg;
         end else if (hit(bus_i.addr, OFF_PORT)) begin
            // Clear config bit marks an analog pin
            next_r.rdata = r.pin_s2 & r.pcfg;
         end else if (hit(bus_i.addr, OFF_STAT)) begin
            next_r.rdata[ST_CONVB] = (r.state == ST_CONVERTING_FLAG);
            next_r.rdata[ST_IRQB] = r.irqf;
            next_r.rdata[ST_PDB] = r.pd;
         end else if (bus_i.addr[4]) begin
            next_r.rdata = fmt(r.form, result_mem[bus_i.addr[3:0]]);
         end
      end

      // Powered-down state lasts until the core leaves sleep
      if (!sleep_i) begin
         next_r.pd = 1'b0;
      end

      // Sequencer; frozen while halted in idle
      if (!halt) begin
         case (r.state)
            ST_IDLE: begin
               if (next_r.sample_enable && next_r.on && !r.pd) begin
                  next_r.state = ST_SAMPLE;
                  next_r.cnt = 5'h00;
               end
            end
            ST_SAMPLE: begin
               if (tick) begin
                  next_r.cnt = r.cnt + 5'h01;
               end
               case (r.ssrc)
                  TRIG_SW: start = !next_r.sample_enable;
                  TRIG_AUTO: start = tick && (r.cnt + 5'h01 >= r.auto_sample_time);
                  TRIG_TMR: start = timer_trig_i;
                  TRIG_EXT: start = ext_trig_i;
                  default: start = 1'b0;
               endcase
               if (start) begin
                  next_r.sample_enable = 1'b0;
                  next_r.cnt = 5'h00;
                  // RC clock waits one cycle so the core can enter sleep
                  next_r.state = r.rc ? ST_WAIT : ST_CONVERTING_FLAG;
               end
            end
            ST_WAIT: begin
               next_r.state = ST_CONVERTING_FLAG;
            end
            ST_CONVERTING_FLAG: begin
               if (tick) begin
                  next_r.cnt = r.cnt + 5'h01;
                  if (r.cnt + 5'h01 == CONVERTING_FLAG_TADS) begin
                     mem_wr = 1'b1;
                     // A digital pin still runs the whole conversion; it stores zero
                     mem_data = r.pcfg[r.chsel] ? '0 : afe_result_i;
                     next_r.idx = r.idx + 4'h1;
                     next_r.smp_cnt = r.smp_cnt + 4'h1;
                     next_r.cnt = 5'h00;
                     next_r.state = ST_IDLE;
                     if (r.smp_cnt == r.samples_per_interrupt) begin
                        // Set wins over a clear in the same cycle
                        next_r.done = 1'b1;
                        next_r.irqf = 1'b1;
                        next_r.smp_cnt = 4'h0;
                        next_r.idx = 4'h0;
                     end
                     if (sleep_i) begin
                        next_r.wake = irq_enable_i;
                        next_r.pd = ~irq_enable_i;
                     end
                  end
               end
            end
            default: begin
               next_r.state = ST_IDLE;
            end
         endcase
      end

      // Sleep on the instruction clock kills a conversion; no resume
      if (sleep_i && !r.rc && (r.state == ST_CONVERTING_FLAG || r.state == ST_WAIT)) begin
         next_r.state = ST_IDLE;
         next_r.cnt = 5'h00;
         mem_wr = 1'b0;
      end

      // Turning off wins over any start this cycle and drops a completing result; done and flag still set
      if (!next_r.on) begin
         next_r.state = ST_IDLE;
         next_r.cnt = 5'h00;
         next_r.acc = 7'h00;
         mem_wr = 1'b0;
      end
   end

   // Control state resets; sleep only aborts a conversion, sets power-down or pulses wake
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{state: ST_IDLE, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // Result buffer has no reset so contents survive a device reset
   always_ff @(posedge clk_i) begin
      if (mem_wr) begin
         result_mem[r.idx] <= mem_data;
      end
   end

   assign rdata_o = r.rdata;
   assign afe_o.channel = r.chsel;
   assign afe_o.sample = (r.state == ST_SAMPLE);
   assign afe_o.convert = (r.state == ST_CONVERTING_FLAG);
   assign afe_o.powered = r.on & ~r.pd;
   assign converting_o = (r.state == ST_CONVERTING_FLAG);
   assign done_o = r.done;
   assign converter_irq_flag_o = r.irqf;
   assign wake_o = r.wake;
endmodule

// >>> verif/sasc_afe_model.sv
// Purpose: analog front end stand-in for the sequencer bench
// Assumes: result is only meaningful while convert is high
// Notes: outside conversion it shows the inverse, so stale reads show
`timescale 1ns/1ps
module sasc_afe_model (
   // Control from the block
   input wire sasc_pkg::sasc_afe_type afe_i,
   // Level to convert and result
   input wire logic [11:0] level_i,
   output logic [11:0] result_o
);
   import sasc_pkg::*;
   assign result_o = afe_i.convert ? level_i : ~level_i;
endmodule

// >>> verif/sasc_top_chk.sv
// Purpose: port assertions of the converter sequencer control
// Assumes: one clock, reset asynchronous active high
// Notes: bound to sasc_top after the module
`timescale 1ns/1ps
module sasc_top_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire sasc_pkg::sasc_bus_type bus_i,
   input wire sasc_pkg::sasc_afe_type afe_o,
   input wire logic sleep_i,
   input wire logic idle_i,
   input wire logic irq_enable_i,
   input wire logic converting_o,
   input wire logic done_o,
   input wire logic converter_irq_flag_o,
   input wire logic wake_o
);
   import sasc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic c1w;
   assign c1w = bus_i.wr && bus_i.addr == OFF_CTRL1;
   a_off_abort: assert property (c1w && !bus_i.wdata[C1_ON] |=>
      (!converting_o && !afe_o.sample && !afe_o.powered) [*2]) else $error("abort missed");
   a_sw_start: assert property (c1w && bus_i.wdata[15] && bus_i.wdata[7:5] == TRIG_SW
      && !bus_i.wdata[1] && afe_o.sample && !idle_i |-> ##[1:2] afe_o.convert)
      else $error("no start");
   a_sample_set: assert property (c1w && bus_i.wdata[15] && bus_i.wdata[1]
      && !converting_o && !idle_i && !sleep_i |=> afe_o.sample) else $error("no sample");
   a_done_len: assert property ($rose(done_o) |->
      $past(converting_o) && $past(converting_o, 15)) else $error("short conversion");
   a_irq_done: assert property ($rose(converter_irq_flag_o) |-> done_o)
      else $error("flag without done");
   a_wake_cause: assert property (wake_o |-> $past(sleep_i) && $past(irq_enable_i)
      ##1 !wake_o) else $error("bad wake");
   // Only the RC path leaves a one-cycle gap between sampling and converting
   a_rc_delay: assert property ($fell(afe_o.sample) && !afe_o.convert
      && afe_o.powered && !idle_i && !(c1w && !bus_i.wdata[C1_ON]) |=> afe_o.convert)
      else $error("no delayed start");
   a_off_quiet: assert property (!afe_o.powered |-> !afe_o.convert)
      else $error("off but converting");
endmodule

bind sasc_top sasc_top_chk i_sasc_top_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
   .afe_o(afe_o), .sleep_i(sleep_i), .idle_i(idle_i), .irq_enable_i(irq_enable_i),
   .converting_o(converting_o), .done_o(done_o),
   .converter_irq_flag_o(converter_irq_flag_o), .wake_o(wake_o));

// >>> verif/sasc_top_tb.sv
// Purpose: self-checking bench of the converter sequencer control
// Assumes: divisor 13, seven cycles per converter clock
// Notes: format cases in a table, the rest hand written
`timescale 1ns/1ps
module sasc_top_tb;
   import sasc_pkg::*;
   logic clk_i = 0;
   logic rst_i = 1;
   logic rc_osc = 0;
   sasc_bus_type bus = '0;
   sasc_afe_type afe;
   logic [15:0] rdata, d, pin = 16'h0000;
   logic [11:0] res, val = 12'h000;
   logic slp = 0, idl = 0, irqen = 0, tmr = 0, ext = 0;
   logic converting_flag, done, irqf, wake, woke = 0;
   int num_errors = 0, comparisons = 0, n;
   // Format, level, expected bus word
   localparam logic [29:0] ROWS [6] = '{
      {FMT_INT, 12'h8a5, 16'h08a5}, {FMT_SINT, 12'h8a5, 16'hf8a5},
      {FMT_FRAC, 12'h8a5, 16'h8a50}, {FMT_SFRAC, 12'h8a5, 16'h8a50},
      {FMT_SINT, 12'h123, 16'h0123}, {FMT_INT, 12'h123, 16'h0123}};
   sasc_top i_sasc_top (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
      .afe_result_i(res), .afe_o(afe), .rc_osc_i(rc_osc), .pin_i(pin), .sleep_i(slp),
      .idle_i(idl), .irq_enable_i(irqen), .timer_trig_i(tmr), .ext_trig_i(ext),
      .converting_o(converting_flag), .done_o(done), .converter_irq_flag_o(irqf), .wake_o(wake));
   sasc_afe_model i_sasc_afe_model (.afe_i(afe), .level_i(val), .result_o(res));
   always #50 clk_i = ~clk_i;
   // Free running and unrelated in phase, as an on-chip RC source is
   always #157 rc_osc = ~rc_osc;
   // The core leaves sleep on the wake pulse
   always @(posedge clk_i) if (wake) begin
      woke <= 1'b1;
      slp <= 1'b0;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus <= '0;
      #1 d = rdata;
   endtask
   task automatic start(input logic [15:0] c);
      wr(OFF_CTRL1, c | 16'h0002);
      if (c[7:5] == TRIG_SW) wr(OFF_CTRL1, c);
      else begin
         @(posedge clk_i);
         tmr <= c[7:5] == TRIG_TMR;
         ext <= c[7:5] == TRIG_EXT;
         @(posedge clk_i);
         tmr <= 1'b0;
         ext <= 1'b0;
      end
   endtask
   task automatic wdone(input logic [15:0] c, input int lo, input int hi);
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk_i) #1;
         n++;
      end
      cmp(16'(n >= lo && n <= hi), 16'h0001);
      cmp(16'(irqf), 16'h0001);
      wr(OFF_CTRL1, c);
      wr(OFF_STAT, 16'h0000);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #3ms;
      num_errors++;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 cmp({12'h000, converting_flag, done, irqf, wake}, 16'h0000);
      rd(OFF_CTRL1);
      cmp(d, 16'h0000);
      rd(5'h0a);
      cmp(d, 16'h0000);
      // Divisor 13 keeps the converter clock at 700 ns
      wr(OFF_CTRL3, 16'h000d);
      for (int i = 0; i < 6; i++) begin
         val = ROWS[i][27:16];
         start({6'h20, ROWS[i][29:28], 8'h00});
         wdone({6'h20, ROWS[i][29:28], 8'h00}, 98, 112);
         rd(OFF_BUF);
         cmp(d, ROWS[i][15:0]);
      end
      $display("end formats");
      wr(OFF_CTRL2, 16'h0004);
      start(16'h8000);
      repeat (130) @(posedge clk_i);
      #1 cmp(16'(done), 16'h0000);
      val = 12'h3c3;
      start(16'h8000);
      wdone(16'h8000, 98, 112);
      rd(OFF_BUF + 5'h01);
      cmp(d, 16'h03c3);
      wr(OFF_CTRL2, 16'h0000);
      for (int i = 1; i < 3; i++) begin
         start({8'h80, 3'(i), 5'h00});
         wdone({8'h80, 3'(i), 5'h00}, 96, 116);
      end
      wr(OFF_CTRL3, 16'h030d);
      wr(OFF_CTRL1, 16'h80e2);
      n = 0;
      while (converting_flag !== 1'b1 && n < 100) begin
         @(posedge clk_i) #1;
         n++;
      end
      cmp(16'(n >= 14 && n <= 28), 16'h0001);
      wdone(16'h80e0, 96, 116);
      wr(OFF_CTRL3, 16'h000d);
      $display("end triggers");
      val = 12'h777;
      start(16'h8000);
      repeat (20) @(posedge clk_i);
      wr(OFF_CTRL1, 16'h0000);
      cmp(16'(converting_flag), 16'h0000);
      // Longer than the 15 converter clocks, 105 cycles, that a whole conversion needs
      repeat (150) @(posedge clk_i);
      #1 cmp(16'(done), 16'h0000);
      rd(OFF_BUF);
      cmp(d, 16'h03c3);
      $display("end abort");
      pin <= 16'hffff;
      wr(OFF_PCFG, 16'h0010);
      wr(OFF_CHSEL, 16'h0004);
      cmp(16'(afe.channel), 16'h0004);
      rd(OFF_PORT);
      cmp(d, 16'h0010);
      start(16'h8000);
      wdone(16'h8000, 98, 112);
      rd(OFF_BUF);
      cmp(d, 16'h0000);
      wr(OFF_CHSEL, 16'h0000);
      start(16'h8000);
      repeat (10) @(posedge clk_i);
      slp <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 cmp(16'(converting_flag), 16'h0000);
      slp <= 1'b0;
      repeat (150) @(posedge clk_i);
      #1 cmp(16'(done), 16'h0000);
      rd(OFF_CTRL1);
      cmp(d, 16'h8000);
      start(16'ha000);
      idl <= 1'b1;
      repeat (200) @(posedge clk_i);
      #1 cmp(16'(converting_flag), 16'h0001);
      idl <= 1'b0;
      wdone(16'ha000, 90, 112);
      $display("end sleep idle");
      val = 12'h5a5;
      irqen <= 1'b1;
      wr(OFF_CTRL3, 16'h008d);
      start(16'h8000);
      slp <= 1'b1;
      wdone(16'h8000, 38, 62);
      cmp(16'(woke), 16'h0001);
      rd(OFF_BUF);
      cmp(d, 16'h05a5);
      wr(OFF_CTRL3, 16'h000d);
      start(16'h8000);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 cmp({12'h000, converting_flag, done, irqf, wake}, 16'h0000);
      rd(OFF_CTRL3);
      cmp(d, 16'h0000);
      rd(OFF_BUF);
      cmp(d, 16'h05a5);
      $display("end reset");
      print_verdict;
   end
endmodule
